// >>> core/spd_ctrl.sv
// Speech presence detector configuration and converter power control.
// Assumes an I2C decoder on clk_in hands over single byte accesses with
// the offset inside the current page; the page register lives here.
//
// Notes on behaviour
// RULE1 - Bits 7-6 of config one pick who powers converters up and down.
// RULE2 - Bits 5-4 of config one pick the monitored channel.
// RULE3 - Bits 3-2 of config one pick the detector clock source.
// RULE4 - Bits 1-0 of config one declare the external clock rate.
// RULE5 - Bit 6 of config two puts the interrupt on the pin when idle.
// RULE6 - Bit 3 of config two keeps detection alive while recording.
// RULE7 - The host writes only reset values to reserved bits of config two.
// RULE8 - Config one sits at page 1 offset 0x1e and resets to 0x20.
// RULE9 - Config two sits at page 1 offset 0x1f and resets to 0x08.
// RULE10 - A page-0 enable bit must be set for the detector to run.
// RULE11 - A page-0 power bit powers enabled converters up or down.
// RULE12 - The host selects page 1 at offset 0x00 before reaching the configs.
// RULE13 - Detected speech raises the interrupt and may power up converters.
`timescale 1ns/100ps
`default_nettype none
module spd_ctrl
  import spd_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // Register access from the I2C decoder
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Detector core status
  input wire logic speech_detect_in,
  input wire logic recording_in,
  // Detector settings
  output logic detector_run_out,
  output logic [1:0] monitored_channel_select_out,
  output logic [1:0] detector_clock_source_out,
  output logic [1:0] external_clock_rate_select_out,
  output logic detector_irq_out,
  // Converter power
  output logic converter_power_out,
  // Serial data out pin interrupt drive
  output logic sdo_irq_out,
  output logic sdo_irq_oe_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] cfg_one;
    logic [7:0] cfg_two;
    logic det_en;
    logic pwr;
    logic run;
    logic irq;
    logic speech_prev;
    logic pin;
    logic pin_oe;
    logic [7:0] rdata;
  } spd_state_t;

  spd_state_t st_q;
  spd_state_t st_d;
  logic speech_sync;
  logic [1:0] auto_mode;
  logic host_up_ok;
  logic host_dn_ok;
  logic det_up_ok;
  logic det_dn_ok;
  logic wr_cfg_one;
  logic wr_cfg_two;
  logic wr_pwr;
  logic rise;
  logic fall;

  // Speech flag comes from the detector's own clock
  spd_sync #(
    .WIDTH(1)
  ) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .async_in(speech_detect_in),
    .sync_out(speech_sync)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // RULE1 power authority
  assign auto_mode = st_q.cfg_one[SPD_AUTO_LSB +: 2];
  assign host_up_ok = (auto_mode == SPD_AUTO_HOST) ||
                      (auto_mode == SPD_AUTO_DET_DOWN);
  assign host_dn_ok = (auto_mode == SPD_AUTO_HOST) ||
                      (auto_mode == SPD_AUTO_DET_UP);
  assign det_up_ok = (auto_mode == SPD_AUTO_DET) ||
                     (auto_mode == SPD_AUTO_DET_UP);
  assign det_dn_ok = (auto_mode == SPD_AUTO_DET) ||
                     (auto_mode == SPD_AUTO_DET_DOWN);
  // RULE8 config one address
  assign wr_cfg_one = reg_wr_in && (st_q.page == SPD_PAGE_ONE) &&
                      (reg_addr_in == SPD_OFS_CFG_ONE);
  // RULE9 config two address
  assign wr_cfg_two = reg_wr_in && (st_q.page == SPD_PAGE_ONE) &&
                      (reg_addr_in == SPD_OFS_CFG_TWO);
  assign wr_pwr = reg_wr_in && (st_q.page == SPD_PAGE_ZERO) &&
                  (reg_addr_in == SPD_OFS_PWR_P0);
  // Edges are seen only while the detector runs
  assign rise = st_q.run && speech_sync && !st_q.speech_prev;
  assign fall = st_q.run && !speech_sync && st_q.speech_prev;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.speech_prev = st_q.run && speech_sync;
    // RULE12 page select
    if (reg_wr_in && (reg_addr_in == SPD_OFS_PAGE)) begin
      st_d.page = reg_wdata_in;
    end
    if (wr_cfg_one) begin
      st_d.cfg_one = reg_wdata_in;
    end
    // RULE7 reserved read-only bits stay zero
    if (wr_cfg_two) begin
      st_d.cfg_two = reg_wdata_in & SPD_CFG_TWO_WMASK;
    end
    // RULE11 host power writes, gated by authority
    if (wr_pwr) begin
      st_d.det_en = reg_wdata_in[SPD_DET_EN_BIT];
      if (reg_wdata_in[SPD_PWR_BIT] && host_up_ok) begin
        st_d.pwr = 1'b1;
      end else if (!reg_wdata_in[SPD_PWR_BIT] && host_dn_ok) begin
        st_d.pwr = 1'b0;
      end
    end
    // RULE13 detector events win over a host write in the same cycle
    if (rise && det_up_ok) begin
      st_d.pwr = 1'b1;
    end else if (fall && det_dn_ok) begin
      st_d.pwr = 1'b0;
    end
    // RULE10 enable gate; RULE6 suspend while recording
    st_d.run = st_d.det_en &&
               (!recording_in || st_d.cfg_two[SPD_DWR_BIT]);
    // RULE13 interrupt follows detected speech
    st_d.irq = st_q.run && speech_sync;
    // RULE5 pin carries the interrupt only when idle
    st_d.pin_oe = st_q.cfg_two[SPD_PIN_IRQ_BIT] && !recording_in;
    st_d.pin = st_d.pin_oe && st_q.run && speech_sync;
    // Read data one cycle after the strobe; unmapped reads zero
    if (reg_rd_in) begin
      st_d.rdata = 8'h00;
      if (reg_addr_in == SPD_OFS_PAGE) begin
        st_d.rdata = st_q.page;
      end else if (st_q.page == SPD_PAGE_ONE &&
                   reg_addr_in == SPD_OFS_CFG_ONE) begin
        st_d.rdata = st_q.cfg_one;
      end else if (st_q.page == SPD_PAGE_ONE &&
                   reg_addr_in == SPD_OFS_CFG_TWO) begin
        st_d.rdata = st_q.cfg_two;
      end else if (st_q.page == SPD_PAGE_ZERO &&
                   reg_addr_in == SPD_OFS_PWR_P0) begin
        st_d.rdata[SPD_PWR_BIT] = st_q.pwr;
        st_d.rdata[SPD_DET_EN_BIT] = st_q.det_en;
      end
    end
  end

  // Single state register, frozen while the enable is low
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= '{page: SPD_RST_PAGE, cfg_one: SPD_RST_CFG_ONE,
                cfg_two: SPD_RST_CFG_TWO, rdata: 8'h00, default: 1'b0};
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // RULE2 channel; RULE3 clock source; RULE4 external rate
  assign monitored_channel_select_out = st_q.cfg_one[SPD_CHAN_LSB +: 2];
  assign detector_clock_source_out = st_q.cfg_one[SPD_CLKSRC_LSB +: 2];
  assign external_clock_rate_select_out = st_q.cfg_one[SPD_RATE_LSB +: 2];
  assign detector_run_out = st_q.run;
  assign detector_irq_out = st_q.irq;
  assign converter_power_out = st_q.pwr;
  assign sdo_irq_out = st_q.pin;
  assign sdo_irq_oe_out = st_q.pin_oe;
  assign reg_rdata_out = st_q.rdata;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_auto_host;
    ce_in && wr_pwr && auto_mode == SPD_AUTO_DET && !rise && !fall
      |=> $stable(converter_power_out);
  endproperty
  a_auto_host: assert property (p_auto_host) // RULE1
    else $error("power changed by host in detector mode");

  property p_chan;
    ce_in && wr_cfg_one |=> monitored_channel_select_out ==
      $past(reg_wdata_in[5:4]);
  endproperty
  a_chan: assert property (p_chan) // RULE2
    else $error("channel select not written");

  property p_clk;
    ce_in && wr_cfg_one |=> detector_clock_source_out ==
      $past(reg_wdata_in[3:2]);
  endproperty
  a_clk: assert property (p_clk) // RULE3
    else $error("clock source not written");

  property p_rate;
    ce_in && wr_cfg_one |=> external_clock_rate_select_out ==
      $past(reg_wdata_in[1:0]);
  endproperty
  a_rate: assert property (p_rate) // RULE4
    else $error("clock rate not written");

  property p_pin;
    ce_in && recording_in |=> !sdo_irq_oe_out;
  endproperty
  a_pin: assert property (p_pin) // RULE5
    else $error("pin driven while recording");

  property p_dwr;
    ce_in && recording_in && !st_d.cfg_two[SPD_DWR_BIT]
      |=> !detector_run_out;
  endproperty
  a_dwr: assert property (p_dwr) // RULE6
    else $error("detector runs while recording");

  property p_rsv;
    ce_in && wr_cfg_two |=> (st_q.cfg_two & ~SPD_CFG_TWO_WMASK) == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) // RULE7
    else $error("read-only bits of config two set");

  property p_en;
    !st_q.det_en |-> !detector_run_out;
  endproperty
  a_en: assert property (p_en) // RULE10
    else $error("detector runs while disabled");

  property p_up;
    ce_in && rise && det_up_ok |=> converter_power_out && detector_irq_out;
  endproperty
  a_up: assert property (p_up) // RULE13
    else $error("speech did not power up converters");

  c_up: cover property (ce_in && rise && det_up_ok);
  c_down: cover property (ce_in && fall && det_dn_ok);
  c_pin: cover property (sdo_irq_oe_out && sdo_irq_out);

endmodule
`default_nettype wire

// >>> core/spd_pkg.sv
// Package for the speech presence detector control block.
// Holds register offsets, field positions, reset values and encodings.
// Assumes an upstream I2C decoder presents byte accesses by offset.
package spd_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SPD_OFS_PAGE = 8'h00;
  localparam logic [7:0] SPD_OFS_CFG_ONE = 8'h1e;
  localparam logic [7:0] SPD_OFS_CFG_TWO = 8'h1f;
  localparam logic [7:0] SPD_OFS_PWR_P0 = 8'h30;
  localparam logic [7:0] SPD_PAGE_ZERO = 8'h00;
  localparam logic [7:0] SPD_PAGE_ONE = 8'h01;

  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] SPD_RST_PAGE = 8'h00;
  localparam logic [7:0] SPD_RST_CFG_ONE = 8'h20;
  localparam logic [7:0] SPD_RST_CFG_TWO = 8'h08;
  localparam logic [7:0] SPD_CFG_TWO_WMASK = 8'hd8;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SPD_AUTO_LSB = 6;
  localparam int SPD_CHAN_LSB = 4;
  localparam int SPD_CLKSRC_LSB = 2;
  localparam int SPD_RATE_LSB = 0;
  localparam int SPD_PIN_IRQ_BIT = 6;
  localparam int SPD_DWR_BIT = 3;
  localparam int SPD_PWR_BIT = 6;
  localparam int SPD_DET_EN_BIT = 0;
  localparam int SPD_SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] SPD_AUTO_HOST = 2'h0;
  localparam logic [1:0] SPD_AUTO_DET = 2'h1;
  localparam logic [1:0] SPD_AUTO_DET_UP = 2'h2;
  localparam logic [1:0] SPD_AUTO_DET_DOWN = 2'h3;
  localparam logic [1:0] SPD_CLK_OSC = 2'h0;
  localparam logic [1:0] SPD_CLK_BIT = 2'h1;
  localparam logic [1:0] SPD_CLK_MASTER = 2'h2;
  localparam logic [1:0] SPD_CLK_CUSTOM = 2'h3;
  localparam logic [1:0] SPD_RATE_3M072 = 2'h0;
  localparam logic [1:0] SPD_RATE_6M144 = 2'h1;
  localparam logic [1:0] SPD_RATE_12M288 = 2'h2;
  localparam logic [1:0] SPD_RATE_18M432 = 2'h3;

endpackage

// >>> core/spd_sync.sv
// Two-flop synchroniser for levels entering from outside the clock domain.
// Assumes the input is a level that holds for several clock periods.
`timescale 1ns/100ps
`default_nettype none
module spd_sync
  import spd_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } spd_sync_state_t;

  spd_sync_state_t st_q;
  spd_sync_state_t st_d;

  // First stage is read only by the second stage
  always_comb begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
  end

  // Both stages freeze while the enable is low
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.sync;

endmodule
`default_nettype wire

// >>> bench/spd_host_model.sv
// Host model: selects the page, then makes single byte accesses.
// Assumes the block takes strobes at the rising edge of clk_in.
`timescale 1ns/100ps
`default_nettype none
module spd_host_model
  import spd_pkg::*;
(
  // Clock and read data
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  // Request
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] data_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    data_out = 8'h00;
  end

  // One strobe held across one edge; lines then show junk, not old values
  task automatic strobe(input logic w, input logic [7:0] a, d);
    @(posedge clk_in);
    #1;
    wr_out = w;
    rd_out = !w;
    addr_out = a;
    data_out = d;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    data_out = ~d;
  endtask

  task automatic wr(input logic [7:0] p, a, d);
    strobe(1'b1, SPD_OFS_PAGE, p);
    strobe(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] p, a, output logic [7:0] v);
    strobe(1'b1, SPD_OFS_PAGE, p);
    strobe(1'b0, a, 8'h00);
    @(posedge clk_in);
    #1;
    v = rdata_in;
  endtask
endmodule
`default_nettype wire

// >>> bench/test_spd_ctrl.sv
// Self-checking bench for the detector configuration and power block.
// Assumes spd_pkg and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_spd_ctrl
  import spd_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce_in = 1'b1;
  logic speech = 1'b0;
  logic rec = 1'b0;
  logic wr, rd, run, irq, pwr, sdo, oe;
  logic [7:0] addr, wdata, rdata, v, c1;
  logic [1:0] ch, cs, rate, m;
  logic [31:0] seed = 32'ha54d577f;
  logic pexp = 1'b0;
  logic req;
  int bad_count = 0;
  int cmp_count = 0;

  always #25 clk_in = ~clk_in;

  spd_ctrl u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .speech_detect_in(speech), .recording_in(rec),
    .detector_run_out(run), .monitored_channel_select_out(ch),
    .detector_clock_source_out(cs), .external_clock_rate_select_out(rate),
    .detector_irq_out(irq), .converter_power_out(pwr),
    .sdo_irq_out(sdo), .sdo_irq_oe_out(oe));

  spd_host_model u_host (.clk_in(clk_in), .rdata_in(rdata), .wr_out(wr),
    .rd_out(rd), .addr_out(addr), .data_out(wdata));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Power after a host write (det=0) or a speech edge (det=1)
  function automatic logic pnext(input logic [1:0] md, input logic p, r, det);
    logic ok;
    ok = det ? (r ? (md == 2'h1 || md == 2'h2) : (md == 2'h1 || md == 2'h3))
             : (r ? (md == 2'h0 || md == 2'h3) : (md == 2'h0 || md == 2'h2));
    return ok ? r : p;
  endfunction

  task automatic chk(input string nm, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #1000000;
    bad_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(8);
    rst_b_in = 1'b1;
    u_host.rd(8'h01, SPD_OFS_CFG_ONE, v);
    chk("cfg_one", v, SPD_RST_CFG_ONE);
    chk("chan", 8'(ch), 8'h02);
    u_host.rd(8'h01, SPD_OFS_CFG_TWO, v);
    chk("cfg_two", v, SPD_RST_CFG_TWO);
    chk("run", 8'(run), 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      m = i[1:0];
      c1 = {m, seed[5:0]};
      u_host.wr(8'h01, SPD_OFS_CFG_ONE, c1);
      chk("chan", 8'(ch), 8'(c1[5:4]));
      chk("clksrc", 8'(cs), 8'(c1[3:2]));
      chk("rate", 8'(rate), 8'(c1[1:0]));
      u_host.rd(8'h01, SPD_OFS_CFG_ONE, v);
      chk("cfg_one", v, c1);
      // reserved bits kept at reset value
      v = seed[15:8] & 8'h48;
      u_host.wr(8'h01, SPD_OFS_CFG_TWO, v);
      u_host.rd(8'h01, SPD_OFS_CFG_TWO, c1);
      chk("cfg_two", c1, v);
      chk("pin_oe", 8'(oe), 8'(v[6]));
      req = seed[16];
      u_host.wr(8'h00, SPD_OFS_PWR_P0, {1'b0, req, 6'h01});
      pexp = pnext(m, pexp, req, 1'b0);
      chk("host_pwr", 8'(pwr), 8'(pexp));
      u_host.rd(8'h00, SPD_OFS_PWR_P0, c1);
      chk("pwr_reg", c1, {1'b0, pexp, 6'h01});
      speech = 1'b1;
      cyc(5);
      pexp = pnext(m, pexp, 1'b1, 1'b1);
      chk("det_up", 8'(pwr), 8'(pexp));
      chk("irq", 8'(irq), 8'h01);
      chk("pin", 8'(sdo), 8'(v[6]));
      speech = 1'b0;
      cyc(5);
      pexp = pnext(m, pexp, 1'b0, 1'b1);
      chk("det_down", 8'(pwr), 8'(pexp));
      chk("irq_off", 8'(irq), 8'h00);
    end
    u_host.wr(8'h01, SPD_OFS_CFG_TWO, 8'h48);
    rec = 1'b1;
    cyc(3);
    chk("rec_run", 8'(run), 8'h01);
    chk("rec_oe", 8'(oe), 8'h00);
    u_host.wr(8'h01, SPD_OFS_CFG_TWO, 8'h40);
    cyc(2);
    chk("rec_stop", 8'(run), 8'h00);
    speech = 1'b1;
    cyc(5);
    chk("irq_held", 8'(irq), 8'h00);
    speech = 1'b0;
    rec = 1'b0;
    cyc(3);
    chk("rec_end", 8'(run), 8'h01);
    // Writes made while the enable is low must not land
    ce_in = 1'b0;
    u_host.wr(8'h01, SPD_OFS_CFG_TWO, 8'h48);
    ce_in = 1'b1;
    u_host.rd(8'h01, SPD_OFS_CFG_TWO, v);
    chk("ce_hold", v, 8'h40);
    u_host.wr(8'h00, SPD_OFS_PWR_P0, 8'h00);
    chk("det_off", 8'(run), 8'h00);
    u_host.wr(8'h01, 8'h05, seed[7:0]);
    u_host.rd(8'h01, 8'h05, v);
    chk("unmapped", v, 8'h00);
    // Second reset in mid-run brings back the reset values
    rst_b_in = 1'b0;
    cyc(2);
    rst_b_in = 1'b1;
    u_host.rd(8'h01, SPD_OFS_CFG_TWO, v);
    chk("rst_cfg_two", v, SPD_RST_CFG_TWO);
    chk("rst_chan", 8'(ch), 8'h02);
    chk("rst_pwr", 8'(pwr), 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
